// [shared/sui_pkg.sv]
package sui_pkg;

    // FIFO geometry: 16 entries each for transmit and receive.
    localparam int unsigned FIFO_DEPTH = 16;
    localparam logic [4:0] FIFO_FULL_COUNT = 5'h10;
    localparam logic [4:0] FIFO_EMPTY_COUNT = 5'h00;

    // Transmit group flag positions.
    localparam int unsigned TX_TRIG = 0;
    localparam int unsigned TX_NOT_FULL = 1;
    localparam int unsigned TX_EMPTY = 2;
    localparam int unsigned TX_OVF = 3;
    localparam int unsigned TX_UNF = 4;
    localparam int unsigned TX_NACK = 5;
    localparam int unsigned TX_DONE = 6;
    localparam int unsigned TX_ARB = 7;

    // Receive group flag positions.
    localparam int unsigned RX_TRIG = 0;
    localparam int unsigned RX_NOT_EMPTY = 1;
    localparam int unsigned RX_FULL = 2;
    localparam int unsigned RX_OVF = 3;
    localparam int unsigned RX_UNF = 4;
    localparam int unsigned RX_FRAME = 5;
    localparam int unsigned RX_PARITY = 6;
    localparam int unsigned RX_BAUD = 7;
    localparam int unsigned RX_BREAK = 8;

    // Master group flag positions.
    localparam int unsigned M_ARB = 0;
    localparam int unsigned M_NACK = 1;
    localparam int unsigned M_ACK = 2;
    localparam int unsigned M_STOP = 3;
    localparam int unsigned M_BUS_ERR = 4;
    localparam int unsigned M_HS_ENTER = 5;
    localparam int unsigned M_HS_EXIT = 6;

    // Slave group flag positions.
    localparam int unsigned S_ARB = 0;
    localparam int unsigned S_NACK = 1;
    localparam int unsigned S_ACK = 2;
    localparam int unsigned S_STOP = 3;
    localparam int unsigned S_START = 4;
    localparam int unsigned S_ADDR = 5;
    localparam int unsigned S_BUS_ERR = 6;
    localparam int unsigned S_RESTART = 7;
    localparam int unsigned S_HS_ENTER = 8;
    localparam int unsigned S_HS_EXIT = 9;

    // Externally clocked group flag positions.
    localparam int unsigned EC_WAKE = 0;
    localparam int unsigned EC_STOP = 1;
    localparam int unsigned EC_WR_STOP = 2;
    localparam int unsigned EC_RD_STOP = 3;

    // Implemented bits of each group; the rest read as zero.
    localparam logic [15:0] TX_USED = 16'h00ff;
    localparam logic [15:0] RX_USED = 16'h01ff;
    localparam logic [15:0] M_USED = 16'h007f;
    localparam logic [15:0] S_USED = 16'h03ff;
    localparam logic [15:0] EC_USED = 16'h000f;

    // One word per interrupt group.
    typedef struct packed {
        logic [15:0] tx;
        logic [15:0] rx;
        logic [15:0] mst;
        logic [15:0] slv;
        logic [15:0] ec;
    } sui_src_t;

    // Pin levels that are synchronised.
    typedef struct packed {
        logic rx_line;
        logic sda;
        logic scl;
    } sui_pins_t;

    // Whole state of the block.
    typedef struct packed {
        sui_pins_t s1;
        sui_pins_t s2;
        sui_src_t flag;
        logic [4:0] brk_cnt;
        logic brk_seen;
        logic [15:0] baud;
        logic addressed;
        logic hs;
    } sui_state_t;

    // Reset values; pin stages start at the idle-high line level so no false low follows reset.
    localparam sui_pins_t PINS_IDLE = 3'h7;
    localparam sui_state_t STATE_RST = {PINS_IDLE, PINS_IDLE, 104'h0};
    localparam logic [4:0] BRK_CNT_MAX = 5'h1f;

endpackage

// [hw/sui_irq_sources.sv]
`timescale 1ns/10ps
// How it works
// R1: Group output is OR of enabled sources.
// R2: Writing one clears only that flag.
// R3: Level sources re-set while condition holds.
// R4: TX trigger, not-full and empty from occupancy.
// R5: Overflow and underflow on bad FIFO accesses.
// R6: SmartCard card NACK raises TX NACK.
// R7: TX done after stop, FIFO and shifter empty.
// R8: TX line differing from RX flags arbitration.
// R9: RX trigger, full and not-empty from occupancy.
// R10: Full receive FIFO discards new frames.
// R11: High at mid start bit flags error.
// R12: Low stop bit flags frame error.
// R13: Parity drop control; SmartCard NACK gives parity.
// R14: LIN baud done flag and baud count.
// R15: Break after width plus one low bits.
// R16: Master arbitration, NACK, ACK, STOP, bus error.
// R17: High-speed enter and exit events.
// R18: Slave SDA mismatch with SCL high aborts.
// R19: Slave stop on end of addressed transfer.
// R20: Start flag suppressed while stretching for wake.
// R21: Address match flag, optional address push.
// R22: Wake and EZ stop events when enabled.
// R23: No write stop for base-address-only writes.
// R24: Masked view is flags AND mask.
// R25: Externally clocked output has no clocked stage; here it comes from ec flags registered on clk_i like the other groups.
// R26: Writing one to set forces the flag.
module sui_irq_sources
    import sui_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire sui_src_t sw_clr_i,
    input wire sui_src_t sw_set_i,
    input wire sui_src_t mask_i,
    input wire logic [4:0] tx_count_i,
    input wire logic [3:0] tx_trigger_level_i,
    input wire logic tx_fw_write_i,
    input wire logic tx_hw_read_i,
    input wire logic tx_shift_empty_i,
    input wire logic tx_stop_sent_i,
    input wire logic smartcard_mode_i,
    input wire logic card_nack_i,
    input wire logic tx_drive_i,
    input wire logic tx_compare_i,
    input wire logic [4:0] rx_count_i,
    input wire logic [3:0] rx_trigger_level_i,
    input wire logic rx_fw_read_i,
    input wire logic rx_line_i,
    input wire logic start_mid_sample_i,
    input wire logic stop_sample_i,
    input wire logic frame_done_i,
    input wire logic parity_error_i,
    input wire logic drop_on_parity_i,
    input wire logic lin_mode_i,
    input wire logic bit_tick_i,
    input wire logic [3:0] break_width_i,
    input wire logic baud_done_i,
    input wire logic [15:0] baud_count_i,
    input wire logic sda_i,
    input wire logic scl_i,
    input wire logic sda_drive_i,
    input wire logic mst_active_i,
    input wire logic slv_active_i,
    input wire logic mst_nack_i,
    input wire logic mst_ack_i,
    input wire logic mst_stop_sent_i,
    input wire logic slv_nack_i,
    input wire logic slv_ack_i,
    input wire logic bus_error_i,
    input wire logic hs_code_nack_i,
    input wire logic start_det_i,
    input wire logic restart_det_i,
    input wire logic stop_det_i,
    input wire logic addr_match_i,
    input wire logic addr_accept_i,
    input wire logic ext_addr_match_on_i,
    input wire logic ext_operation_on_i,
    input wire logic nack_address_when_unready_i,
    input wire logic ez_mode_i,
    input wire logic xfer_is_write_i,
    input wire logic xfer_is_read_i,
    input wire logic ez_data_written_i,
    output sui_src_t flags_o,
    output sui_src_t masked_o,
    output logic tx_int_o,
    output logic rx_int_o,
    output logic master_int_o,
    output logic slave_int_o,
    output logic ec_int_o,
    output logic [4:0] interrupt_group_cause_o,
    output logic rx_fifo_write_o,
    output logic rx_push_address_o,
    output logic lin_abort_o,
    output logic baud_detect_start_o,
    output logic [15:0] baud_measure_count_o,
    output logic slave_abort_o
);

    // Registered state and its next value.
    sui_state_t q;
    sui_state_t d;
    // Events of this cycle, one word per group.
    sui_src_t ev;
    // Helper for checks: bits cleared with nothing to re-set them.
    logic [15:0] mst_clr_only;
    // Occupancy decodes.
    logic tx_empty;
    logic tx_full;
    logic rx_empty;
    logic rx_full;
    // Break detection decodes.
    logic brk_ev;
    logic [4:0] brk_target;
    logic [4:0] brk_next;

    // Flag update: set wins over clear, so an event in the clear cycle survives.
    function automatic logic [15:0] sui_upd(input logic [15:0] flag, input logic [15:0] evt,
                                            input logic [15:0] clr, input logic [15:0] set,
                                            input logic [15:0] used);
        sui_upd = ((flag & ~clr) | evt | set) & used; // R2 R26
    endfunction

    // Next state and all event decoding.
    always_comb begin
        d = q;
        ev = '0;
        // Pins pass two flops; only the second stage is read below.
        d.s1.rx_line = rx_line_i;
        d.s1.sda = sda_i;
        d.s1.scl = scl_i;
        d.s2 = q.s1;

        tx_empty = (tx_count_i == FIFO_EMPTY_COUNT);
        tx_full = (tx_count_i == FIFO_FULL_COUNT);
        rx_empty = (rx_count_i == FIFO_EMPTY_COUNT);
        rx_full = (rx_count_i == FIFO_FULL_COUNT);

        // Transmit sources; level ones fire every cycle their condition holds.
        ev.tx[TX_TRIG] = (tx_count_i < {1'b0, tx_trigger_level_i}); // R4 R3
        ev.tx[TX_NOT_FULL] = !tx_full; // R4
        ev.tx[TX_EMPTY] = tx_empty; // R4 R3
        ev.tx[TX_OVF] = tx_fw_write_i && tx_full; // R5
        ev.tx[TX_UNF] = tx_hw_read_i && tx_empty; // R5
        ev.tx[TX_NACK] = smartcard_mode_i && card_nack_i; // R6
        ev.tx[TX_DONE] = tx_stop_sent_i && tx_empty && tx_shift_empty_i; // R7
        // The compare point comes from the engine after the line has settled.
        ev.tx[TX_ARB] = tx_compare_i && (tx_drive_i != q.s2.rx_line); // R8

        // Break: count whole low bit periods, fire once at width plus one.
        brk_target = {1'b0, break_width_i} + 5'h01;
        brk_next = q.brk_cnt;
        if (q.s2.rx_line) begin
            brk_next = '0;
        end else if (bit_tick_i && q.brk_cnt != BRK_CNT_MAX) begin
            brk_next = q.brk_cnt + 5'h01;
        end
        brk_ev = !q.brk_seen && !q.s2.rx_line && (brk_next >= brk_target); // R15
        d.brk_cnt = brk_next;
        if (q.s2.rx_line) begin
            // Line released: arm for the next break.
            d.brk_seen = 1'b0;
        end else if (brk_ev) begin
            d.brk_seen = 1'b1;
        end

        // Frame storage: full FIFO, parity drop and LIN break all discard.
        rx_fifo_write_o = frame_done_i && !rx_full && !(parity_error_i && drop_on_parity_i) // R10 R13
                          && !(lin_mode_i && brk_ev); // R15
        rx_push_address_o = addr_match_i && addr_accept_i && !rx_full; // R21

        // Receive sources.
        ev.rx[RX_TRIG] = (rx_count_i > {1'b0, rx_trigger_level_i}); // R9 R3
        ev.rx[RX_NOT_EMPTY] = !rx_empty; // R9
        ev.rx[RX_FULL] = rx_full; // R9
        ev.rx[RX_OVF] = rx_full && (frame_done_i || (addr_match_i && addr_accept_i)); // R5 R10
        ev.rx[RX_UNF] = rx_fw_read_i && rx_empty; // R5
        ev.rx[RX_FRAME] = (start_mid_sample_i && q.s2.rx_line) // R11
                          || (stop_sample_i && !q.s2.rx_line); // R12
        ev.rx[RX_PARITY] = (frame_done_i && parity_error_i) || (smartcard_mode_i && card_nack_i); // R13
        ev.rx[RX_BAUD] = baud_done_i; // R14
        ev.rx[RX_BREAK] = brk_ev; // R15
        lin_abort_o = lin_mode_i && brk_ev; // R15
        baud_detect_start_o = lin_mode_i && brk_ev; // R15
        if (baud_done_i) begin
            d.baud = baud_count_i; // R14
        end

        // Master sources; arbitration only counts while SCL is high.
        ev.mst[M_ARB] = mst_active_i && q.s2.scl && (sda_drive_i != q.s2.sda); // R16
        ev.mst[M_NACK] = mst_nack_i; // R16
        ev.mst[M_ACK] = mst_ack_i; // R16
        ev.mst[M_STOP] = mst_stop_sent_i; // R16
        ev.mst[M_BUS_ERR] = bus_error_i; // R16
        ev.mst[M_HS_ENTER] = hs_code_nack_i; // R17
        ev.mst[M_HS_EXIT] = stop_det_i && q.hs; // R17

        // High-speed state: entered on the coded NACK, left on any STOP.
        if (hs_code_nack_i) begin
            d.hs = 1'b1;
        end else if (stop_det_i) begin
            d.hs = 1'b0;
        end

        // Slave sources.
        ev.slv[S_ARB] = slv_active_i && q.s2.scl && (sda_drive_i != q.s2.sda); // R18
        slave_abort_o = ev.slv[S_ARB]; // R18
        ev.slv[S_NACK] = slv_nack_i;
        ev.slv[S_ACK] = slv_ack_i;
        ev.slv[S_STOP] = (stop_det_i || restart_det_i) && q.addressed; // R19
        // While the slave stretches for wake-up the start is not reported.
        ev.slv[S_START] = (start_det_i || restart_det_i)
                          && !(ext_addr_match_on_i && !nack_address_when_unready_i); // R20
        ev.slv[S_ADDR] = addr_match_i; // R21
        ev.slv[S_BUS_ERR] = bus_error_i;
        ev.slv[S_RESTART] = restart_det_i;
        ev.slv[S_HS_ENTER] = hs_code_nack_i; // R17
        ev.slv[S_HS_EXIT] = stop_det_i && q.hs; // R17

        // Addressed marks a transfer for this slave, ACKed or not.
        if (addr_match_i) begin
            d.addressed = 1'b1; // R19
        end else if (stop_det_i || restart_det_i) begin
            d.addressed = 1'b0;
        end

        // Externally clocked sources.
        ev.ec[EC_WAKE] = addr_match_i && ext_addr_match_on_i; // R22
        ev.ec[EC_STOP] = stop_det_i && q.addressed && ez_mode_i && ext_operation_on_i; // R22
        ev.ec[EC_WR_STOP] = ev.ec[EC_STOP] && xfer_is_write_i && ez_data_written_i; // R22 R23
        ev.ec[EC_RD_STOP] = ev.ec[EC_STOP] && xfer_is_read_i; // R22

        // Flag update per group.
        d.flag.tx = sui_upd(q.flag.tx, ev.tx, sw_clr_i.tx, sw_set_i.tx, TX_USED);
        d.flag.rx = sui_upd(q.flag.rx, ev.rx, sw_clr_i.rx, sw_set_i.rx, RX_USED);
        d.flag.mst = sui_upd(q.flag.mst, ev.mst, sw_clr_i.mst, sw_set_i.mst, M_USED);
        d.flag.slv = sui_upd(q.flag.slv, ev.slv, sw_clr_i.slv, sw_set_i.slv, S_USED);
        d.flag.ec = sui_upd(q.flag.ec, ev.ec, sw_clr_i.ec, sw_set_i.ec, EC_USED);

        mst_clr_only = sw_clr_i.mst & ~sw_set_i.mst & ~ev.mst;
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    // Views and group outputs straight from the flag flops.
    assign flags_o = q.flag;
    assign masked_o = q.flag & mask_i; // R24
    assign tx_int_o = |masked_o.tx; // R1
    assign rx_int_o = |masked_o.rx; // R1
    assign master_int_o = |masked_o.mst; // R1
    assign slave_int_o = |masked_o.slv; // R1
    // No extra flop on this path, so it follows the flags without a clocked stage.
    assign ec_int_o = |masked_o.ec; // R1 R25
    assign interrupt_group_cause_o = {ec_int_o, slave_int_o, master_int_o, rx_int_o, tx_int_o};
    assign baud_measure_count_o = q.baud;

    // The tx group output follows its enabled tx flags.
    group_or_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        tx_int_o == |(flags_o.tx & mask_i.tx))
        else $error("tx group output disagrees with enabled flags");

    // A clear without a new cause removes the flag next cycle.
    clear_one_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        1'b1 |=> ((flags_o.mst & $past(mst_clr_only)) == 16'h0000))
        else $error("master flag survived a clear");

    // Empty FIFO keeps the empty flag set even across clears.
    empty_reset_a: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        (tx_count_i == FIFO_EMPTY_COUNT) |=> flags_o.tx[TX_EMPTY])
        else $error("tx empty flag not set while empty");

    // Trigger follows level compare.
    tx_trigger_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        (tx_count_i < {1'b0, tx_trigger_level_i}) |=> flags_o.tx[TX_TRIG])
        else $error("tx trigger missed");

    // Full receive FIFO never takes a frame.
    rx_full_drop_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        (rx_count_i == FIFO_FULL_COUNT) |-> !rx_fifo_write_o)
        else $error("frame stored into full rx fifo");

    // Parity drop control discards the frame but flags it.
    parity_drop_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        (frame_done_i && parity_error_i && drop_on_parity_i) |-> !rx_fifo_write_o ##1 flags_o.rx[RX_PARITY])
        else $error("parity frame not dropped or not flagged");

    // Suppressed start while stretching for wake-up.
    slave_start_a: assert property (@(posedge clk_i) disable iff (rst_i) // R20
        (ext_addr_match_on_i && !nack_address_when_unready_i && !flags_o.slv[S_START]
         && !sw_set_i.slv[S_START]) |=> !flags_o.slv[S_START])
        else $error("slave start set while stretching");

    // Wake only with external matching on.
    ec_wake_a: assert property (@(posedge clk_i) disable iff (rst_i) // R22
        (!flags_o.ec[EC_WAKE] && !ext_addr_match_on_i && !sw_set_i.ec[EC_WAKE]) |=> !flags_o.ec[EC_WAKE])
        else $error("wake flag without external matching");

    // Software set forces the flag.
    set_force_a: assert property (@(posedge clk_i) disable iff (rst_i) // R26
        sw_set_i.rx[RX_BREAK] |=> flags_o.rx[RX_BREAK])
        else $error("set did not force break flag");

    // A LIN abort comes with baud detect start and leaves the break flag behind.
    break_lin_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
        lin_abort_o |-> baud_detect_start_o ##1 flags_o.rx[RX_BREAK])
        else $error("break abort without flag");

    // A firmware write into a full transmit FIFO is flagged.
    tx_overflow_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        (tx_fw_write_i && tx_count_i == FIFO_FULL_COUNT) |=> flags_o.tx[TX_OVF])
        else $error("tx overflow missed");

    // Done never rises while data is still waiting in the FIFO.
    tx_done_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        (tx_stop_sent_i && tx_count_i != FIFO_EMPTY_COUNT && !flags_o.tx[TX_DONE]
         && !sw_set_i.tx[TX_DONE]) |=> !flags_o.tx[TX_DONE])
        else $error("tx done with data left");

    // High-speed entry reaches both master and slave groups.
    hs_enter_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
        hs_code_nack_i |=> (flags_o.mst[M_HS_ENTER] && flags_o.slv[S_HS_ENTER]))
        else $error("high speed entry not flagged");

    // An abort always leaves the slave arbitration flag behind.
    slave_abort_a: assert property (@(posedge clk_i) disable iff (rst_i) // R18
        slave_abort_o |=> flags_o.slv[S_ARB])
        else $error("slave abort without flag");

    // An address push only happens on a match, which is flagged.
    addr_push_a: assert property (@(posedge clk_i) disable iff (rst_i) // R21
        rx_push_address_o |-> addr_match_i ##1 flags_o.slv[S_ADDR])
        else $error("address push without match flag");

    // Without data beyond the base address the write stop stays clear.
    write_stop_a: assert property (@(posedge clk_i) disable iff (rst_i) // R23
        (!ez_data_written_i && !flags_o.ec[EC_WR_STOP] && !sw_set_i.ec[EC_WR_STOP]) |=> !flags_o.ec[EC_WR_STOP])
        else $error("write stop on base address only");

endmodule

// [dv/sui_fw_model.sv]
`timescale 1ns/10ps
// Firmware side: each requested write reaches the block one cycle later as a strobe held while the request is.
module sui_fw_model
    import sui_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire sui_src_t clr_req_i,
    input wire sui_src_t set_req_i,
    output sui_src_t sw_clr_o,
    output sui_src_t sw_set_o
);
    // Strobes repeat every cycle the request is held, so a held request clears again each cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i || !req_i) begin
            sw_clr_o <= '0;
            sw_set_o <= '0;
        end else begin
            sw_clr_o <= clr_req_i;
            sw_set_o <= set_req_i;
        end
    end
endmodule

// [dv/tb.sv]
`timescale 1ns/10ps
module tb
    import sui_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, req = 1'b0;
    logic rx_line_i = 1'b1, sda_i = 1'b1, scl_i = 1'b1;
    logic [21:0] ev = '0; // Event strobes, one bit per pulse input.
    logic [16:0] lv = '0; // Level controls.
    logic [4:0] tx_count_i = 5'h10, rx_count_i = 5'h00, snap;
    logic [3:0] tx_trigger_level_i = 4'h0, rx_trigger_level_i = 4'h0, break_width_i = 4'h0;
    logic [15:0] baud_count_i = 16'h0000, baud_measure_count_o;
    logic [4:0] interrupt_group_cause_o, ints;
    logic tx_int_o, rx_int_o, master_int_o, slave_int_o, ec_int_o;
    logic rx_fifo_write_o, rx_push_address_o, lin_abort_o, baud_detect_start_o, slave_abort_o;
    sui_src_t sw_clr_i, sw_set_i, flags_o, masked_o, e, clr_req, set_req, all1, mask_i = '0;
    int n_mismatch = 0, samples_checked = 0, cyc = 0, tc, tl, rc, rl, bw;
    int tk[14] = '{0, 5, 3, 3, 10, 11, 12, 13, 16, 14, 15, 18, 21, 19};
    int tp[14] = '{67, 52, 69, 54, 55, 33, 34, 35, 36, 17, 18, 20, 21, 23};
    always #2.5 clk_i = ~clk_i;
    sui_irq_sources u_sui_irq_sources (.clk_i(clk_i), .rst_i(rst_i), .sw_clr_i(sw_clr_i), .sw_set_i(sw_set_i),
        .mask_i(mask_i), .tx_count_i(tx_count_i), .tx_trigger_level_i(tx_trigger_level_i),
        .tx_fw_write_i(ev[0]), .tx_hw_read_i(ev[1]), .tx_shift_empty_i(lv[0]), .tx_stop_sent_i(ev[2]),
        .smartcard_mode_i(lv[1]), .card_nack_i(ev[3]), .tx_drive_i(lv[2]), .tx_compare_i(ev[4]),
        .rx_count_i(rx_count_i), .rx_trigger_level_i(rx_trigger_level_i), .rx_fw_read_i(ev[5]),
        .rx_line_i(rx_line_i), .start_mid_sample_i(ev[6]), .stop_sample_i(ev[7]), .frame_done_i(ev[8]),
        .parity_error_i(lv[3]), .drop_on_parity_i(lv[4]), .lin_mode_i(lv[5]), .bit_tick_i(ev[9]),
        .break_width_i(break_width_i), .baud_done_i(ev[10]), .baud_count_i(baud_count_i), .sda_i(sda_i),
        .scl_i(scl_i), .sda_drive_i(lv[6]), .mst_active_i(lv[7]), .slv_active_i(lv[8]), .mst_nack_i(ev[11]),
        .mst_ack_i(ev[12]), .mst_stop_sent_i(ev[13]), .slv_nack_i(ev[14]), .slv_ack_i(ev[15]),
        .bus_error_i(ev[16]), .hs_code_nack_i(ev[17]), .start_det_i(ev[18]), .restart_det_i(ev[19]),
        .stop_det_i(ev[20]), .addr_match_i(ev[21]), .addr_accept_i(lv[9]), .ext_addr_match_on_i(lv[10]),
        .ext_operation_on_i(lv[11]), .nack_address_when_unready_i(lv[12]), .ez_mode_i(lv[13]),
        .xfer_is_write_i(lv[14]), .xfer_is_read_i(lv[15]), .ez_data_written_i(lv[16]), .flags_o(flags_o),
        .masked_o(masked_o), .tx_int_o(tx_int_o), .rx_int_o(rx_int_o), .master_int_o(master_int_o),
        .slave_int_o(slave_int_o), .ec_int_o(ec_int_o), .interrupt_group_cause_o(interrupt_group_cause_o),
        .rx_fifo_write_o(rx_fifo_write_o), .rx_push_address_o(rx_push_address_o), .lin_abort_o(lin_abort_o),
        .baud_detect_start_o(baud_detect_start_o), .baud_measure_count_o(baud_measure_count_o),
        .slave_abort_o(slave_abort_o));
    sui_fw_model u_sui_fw_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .clr_req_i(clr_req),
        .set_req_i(set_req), .sw_clr_o(sw_clr_i), .sw_set_o(sw_set_i));
    // Inputs move one nanosecond after the edge so no race with the design's sampling.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic cmp(input logic [79:0] g, input logic [79:0] x);
        samples_checked++;
        if (g !== x) begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, g, x);
        end
    endtask
    // A firmware write; flags reflect it when the task returns.
    task automatic fw(input sui_src_t c, input sui_src_t s);
        clr_req = c;
        set_req = s;
        req = 1'b1;
        tick(1);
        req = 1'b0;
        tick(1);
    endtask
    // One strobe; the combinational outputs are captured while it is high.
    task automatic fire(input int k);
        ev[k] = 1'b1;
        #1;
        snap = {rx_fifo_write_o, rx_push_address_o, lin_abort_o, baud_detect_start_o, slave_abort_o};
        tick(1);
        ev = '0;
    endtask
    function automatic logic [79:0] bm(input int p);
        return 80'(1) << p;
    endfunction
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // A hang is cut short well beyond the fewer than two hundred cycles the run needs.
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        {clr_req, set_req, all1} = '0;
        all1 = '1;
        void'($urandom(32'h6078));
        tick(16);
        rst_i = 1'b0;
        tick(1);
        cmp(flags_o, '0);
        // Occupancy sources come straight back after a clear while they hold.
        for (int i = 0; i < 20; i++) begin
            tc = $urandom_range(16);
            tl = $urandom_range(15);
            rc = $urandom_range(16);
            rl = $urandom_range(15);
            {tx_count_i, rx_count_i} = {5'(tc), 5'(rc)};
            {tx_trigger_level_i, rx_trigger_level_i} = {4'(tl), 4'(rl)};
            fw(all1, '0);
            e = '0;
            e.tx[2:0] = {tc == 0, tc < 16, tc < tl};
            e.rx[2:0] = {rc == 16, rc != 0, rc > rl};
            cmp(flags_o, e);
            mask_i = sui_src_t'({$urandom, $urandom, $urandom});
            #1;
            e = e & mask_i;
            ints = {|e.ec, |e.slv, |e.mst, |e.rx, |e.tx};
            cmp(masked_o, e);
            cmp(80'({ec_int_o, slave_int_o, master_int_o, rx_int_o, tx_int_o}), 80'(ints));
            cmp(80'(interrupt_group_cause_o), 80'(ints));
        end
        // Quiet occupancy, then set everything and clear one bit.
        {tx_count_i, rx_count_i, tx_trigger_level_i, rx_trigger_level_i} = {5'h10, 5'h00, 4'h0, 4'h0};
        fw('0, all1);
        e = {TX_USED, RX_USED, M_USED, S_USED, EC_USED};
        cmp(flags_o, e);
        fw(sui_src_t'(bm(48 + RX_BAUD)), '0);
        cmp(flags_o, e & ~bm(48 + RX_BAUD));
        lv[1] = 1'b1;
        for (int i = 0; i < 14; i++) begin
            baud_count_i = 16'($urandom);
            fw(all1, '0);
            fire(tk[i]);
            cmp(flags_o & bm(tp[i]), bm(tp[i]));
            if (tk[i] == 10) cmp(80'(baud_measure_count_o), 80'(baud_count_i));
        end
        // High-speed entry and exit; the slave is no longer addressed here.
        fw(all1, '0);
        fire(17);
        cmp(flags_o & (bm(37) | bm(24)), bm(37) | bm(24));
        fire(20);
        cmp(flags_o & (bm(38) | bm(25) | bm(19)), bm(38) | bm(25));
        // Frame store versus full FIFO and parity drop.
        for (int i = 0; i < 8; i++) begin
            rx_count_i = i[0] ? 5'h10 : 5'h03;
            {lv[4], lv[3]} = 2'(i >> 1);
            fw(all1, '0);
            fire(8);
            cmp(80'(snap[4]), 80'(!i[0] && !(i[1] && i[2])));
            cmp(flags_o & (bm(51) | bm(54)), (i[0] ? bm(51) : 80'(0)) | (i[1] ? bm(54) : 80'(0)));
        end
        rx_count_i = 5'h00;
        // Start and stop sample points, and transmit line compare.
        lv[2] = 1'b1;
        for (int j = 0; j < 4; j++) begin
            rx_line_i = j[0];
            tick(3);
            fw(all1, '0);
            fire(j[1] ? 6 : 7);
            fire(4);
            cmp(flags_o & bm(53), (j[1] == j[0]) ? bm(53) : 80'(0));
            cmp(flags_o & bm(71), j[0] ? 80'(0) : bm(71));
        end
        // Break after width plus one low bit periods in LIN mode.
        bw = $urandom_range(5);
        break_width_i = 4'(bw);
        lv[5] = 1'b1;
        rx_line_i = 1'b0;
        tick(3);
        fw(all1, '0);
        repeat (bw) fire(9);
        cmp(flags_o & bm(56), '0);
        fire(9);
        cmp(80'(snap[2:1]), 80'(3));
        cmp(flags_o & bm(56), bm(56));
        fire(9);
        cmp(80'(snap[2:1]), 80'(0));
        rx_line_i = 1'b1;
        // Transmit done and underflow with an empty FIFO, no done with data left.
        {lv[0], tx_count_i} = {1'b1, 5'h00};
        fw(all1, '0);
        fire(2);
        fire(1);
        cmp(flags_o & (bm(70) | bm(68)), bm(70) | bm(68));
        tx_count_i = 5'h01;
        fw(all1, '0);
        fire(2);
        cmp(flags_o & bm(70), '0);
        // Externally clocked wake and EZ stop events.
        lv[16:9] = 8'b0011_0111;
        for (int w = 0; w < 2; w++) begin
            lv[16] = w[0];
            lv[15] = w[0];
            fw(all1, '0);
            fire(18);
            cmp(flags_o & bm(20), '0);
            fire(21);
            cmp(80'(snap[3]), 80'(1));
            fire(20);
            e = bm(EC_WAKE) | bm(EC_STOP) | bm(19) | (w ? (bm(EC_WR_STOP) | bm(EC_RD_STOP)) : 80'(0));
            cmp(flags_o & (bm(19) | 80'(16'h000f)), e);
        end
        // SDA observed low while driven released with SCL high.
        {lv[8], lv[7], lv[6], sda_i} = 4'b1110;
        tick(6);
        cmp(flags_o & (bm(32) | bm(16)), bm(32) | bm(16));
        cmp(80'(slave_abort_o), 80'(1));
        test_done();
    end
endmodule
